/* core/ddr3_timing_pkg.sv */
// Constants shared by the DDR3 command timing tracker
package ddr3_timing_pkg;
	// Register byte offsets
	localparam logic [7:0] LATENCY_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h04;
	localparam logic [7:0] TIMING_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] EDGES_OFS = 8'h10;
	// Reset values
	localparam logic [31:0] LATENCY_RST = 32'h0006_0006;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [31:0] TIMING_RST = 32'h0006_060F;
	// Field positions
	localparam int RL_LSB = 0;
	localparam int AL_LSB = 8;
	localparam int WL_LSB = 16;
	localparam int LAT_W = 5;
	localparam int BURST_LSB = 0;
	localparam int DLL_DISABLED_MODE_BIT = 2;
	localparam int RAS_LSB = 0;
	localparam int RP_LSB = 8;
	localparam int WR_LSB = 16;
	localparam int VIOL_BIT = 0;
	localparam int OPEN_LSB = 8;
	localparam int PEND_LSB = 16;
	// Burst modes in the mode register
	localparam logic [1:0] BURST_FIXED_8 = 2'h0;
	localparam logic [1:0] BURST_OTF = 2'h1;
	localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;
	// Write recovery start offsets after write latency, and the write recovery minimum with the DLL off
	localparam logic [7:0] WR_START_LONG = 8'h04;
	localparam logic [7:0] WR_START_CHOP = 8'h02;
	localparam logic [7:0] DLL_OFF_WR_MIN = 8'h04;
	// Internal command codes, decoded from the pins {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_READ = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_PRE = 3'h4,
		CMD_REF = 3'h5
	} cmd_t;
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_LEAD = 2'h1,
		WR_REC = 2'h2
	} wr_state_t;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/ddr3_cmd_timing.sv */
// DDR3 device-side command timing tracker with an AXI4-Lite register slave
//Contract
// - Cycle delays count real rising edges of the input clock.
// - DLL off: read strobe window starts read plus additive latency minus one after READ.
// - Auto-precharge is held off until the bank's row active minimum has elapsed.
// - Write recovery starts 4 clocks after write latency, 2 for fixed chop.
// - Device accepts spacings of the time limit over average period, rounded up.
//
// Added by the designer: the address map and register access over AXI4-Lite.
module ddr3_cmd_timing #(
	parameter int BANKS = 8
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// Memory pins
	input wire logic DDR_CK_I,
	input wire logic DDR_CKE_I,
	input wire logic DDR_RESET_N_I,
	input wire logic DDR_CS_N_I,
	input wire logic DDR_RAS_N_I,
	input wire logic DDR_CAS_N_I,
	input wire logic DDR_WE_N_I,
	input wire logic [2:0] DDR_BA_I,
	input wire logic DDR_A10_I,
	input wire logic DDR_A12_I,
	// Timing events
	output logic READ_WINDOW_O,
	output logic WR_RECOVERY_O,
	output logic AUTO_PRE_O,
	output logic [2:0] AUTO_PRE_BANK_O,
	// AXI4-Lite slave
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I
);
	initial begin
		if (BANKS != 8) $error("BANKS must be 8, bank address is three bits");
	end

	function automatic ddr3_timing_pkg::cmd_t cmd_decode(input logic [3:0] c);
		case (c)
			4'h3: cmd_decode = ddr3_timing_pkg::CMD_ACT;
			4'h5: cmd_decode = ddr3_timing_pkg::CMD_READ;
			4'h4: cmd_decode = ddr3_timing_pkg::CMD_WRITE;
			4'h2: cmd_decode = ddr3_timing_pkg::CMD_PRE;
			4'h1: cmd_decode = ddr3_timing_pkg::CMD_REF;
			default: cmd_decode = ddr3_timing_pkg::CMD_NOP;
		endcase
	endfunction

	function automatic logic addr_ok(input logic [7:0] a, input logic wr);
		addr_ok = (a == ddr3_timing_pkg::LATENCY_OFS) || (a == ddr3_timing_pkg::MODE_OFS) ||
			(a == ddr3_timing_pkg::TIMING_OFS) || (a == ddr3_timing_pkg::STATUS_OFS) ||
			(!wr && a == ddr3_timing_pkg::EDGES_OFS);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	// Pin synchronisers; only the clock pin gets a third stage for edge finding
	logic [11:0] pin_raw;
	logic [11:0] pin_m_r;
	logic [11:0] pin_s_r;
	logic ck_d_r;
	assign pin_raw = {DDR_CK_I, DDR_CKE_I, DDR_RESET_N_I, DDR_CS_N_I, DDR_RAS_N_I,
		DDR_CAS_N_I, DDR_WE_N_I, DDR_BA_I, DDR_A10_I, DDR_A12_I};
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_m_r <= 12'h000;
			pin_s_r <= 12'h000;
			ck_d_r <= 1'b0;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
			ck_d_r <= pin_s_r[11];
		end
	end
	logic ck_edge;
	logic [2:0] ba;
	assign ck_edge = pin_s_r[11] && !ck_d_r;
	assign ba = pin_s_r[4:2];

	// Software registers
	logic [31:0] lat_r, lat_nxt, mode_r, mode_nxt, tim_r, tim_nxt;
	localparam int LAT_W_C = ddr3_timing_pkg::LAT_W;
	logic sw_clr;
	logic [LAT_W_C-1:0] rl, al, wl;
	assign rl = lat_r[ddr3_timing_pkg::RL_LSB +: LAT_W_C];
	assign al = lat_r[ddr3_timing_pkg::AL_LSB +: LAT_W_C];
	assign wl = lat_r[ddr3_timing_pkg::WL_LSB +: LAT_W_C];
	logic [7:0] row_active_min_time, trp, write_recovery_time, twr_eff;
	assign row_active_min_time = tim_r[ddr3_timing_pkg::RAS_LSB +: 8];
	assign trp = tim_r[ddr3_timing_pkg::RP_LSB +: 8];
	assign write_recovery_time = tim_r[ddr3_timing_pkg::WR_LSB +: 8];
	assign twr_eff = (mode_r[ddr3_timing_pkg::DLL_DISABLED_MODE_BIT] && write_recovery_time < ddr3_timing_pkg::DLL_OFF_WR_MIN)
		? ddr3_timing_pkg::DLL_OFF_WR_MIN : write_recovery_time;

	// Timing tracker state
	logic [31:0] edges_r, edges_nxt, rd_tgt_r, rd_tgt_nxt, wr_tgt_r, wr_tgt_nxt;
	logic [5:0] rd_cnt_r, rd_cnt_nxt;
	logic [7:0] wr_cnt_r, wr_cnt_nxt;
	ddr3_timing_pkg::wr_state_t wr_st_r, wr_st_nxt;
	logic [BANKS-1:0] open_r, open_nxt, pend_r, pend_nxt, pwr_r, pwr_nxt;
	logic [7:0] ras_r [BANKS], ras_nxt [BANKS], rp_r [BANKS], rp_nxt [BANKS];
	logic viol_r, viol_nxt, rdw_nxt, wrr_nxt, ap_nxt;
	logic [2:0] ap_bank_nxt;

	always_comb begin
		logic [5:0] rd_lat;
		logic found;
		logic viol_set;
		rd_lat = ({1'b0, rl} + {1'b0, al} == 6'h00) ? 6'h00 : {1'b0, rl} + {1'b0, al} - 6'h01;
		found = 1'b0;
		viol_set = 1'b0;
		edges_nxt = edges_r;
		rd_tgt_nxt = rd_tgt_r;
		wr_tgt_nxt = wr_tgt_r;
		rd_cnt_nxt = rd_cnt_r;
		wr_cnt_nxt = wr_cnt_r;
		wr_st_nxt = wr_st_r;
		open_nxt = open_r;
		pend_nxt = pend_r;
		pwr_nxt = pwr_r;
		ras_nxt = ras_r;
		rp_nxt = rp_r;
		rdw_nxt = 1'b0;
		wrr_nxt = 1'b0;
		ap_nxt = 1'b0;
		ap_bank_nxt = AUTO_PRE_BANK_O;
		if (!pin_s_r[9]) begin
			// Memory reset pin low: forget every bank and burst in flight
			rd_cnt_nxt = 6'h00;
			wr_st_nxt = ddr3_timing_pkg::WR_IDLE;
			open_nxt = '0;
			pend_nxt = '0;
			pwr_nxt = '0;
		end else if (ck_edge) begin
			edges_nxt = edges_r + 32'h0000_0001;
			for (int b = 0; b < BANKS; b++) begin
				if (ras_r[b] != 8'hFF) ras_nxt[b] = ras_r[b] + 8'h01;
				if (rp_r[b] != 8'hFF) rp_nxt[b] = rp_r[b] + 8'h01;
			end
			if (rd_cnt_r != 6'h00) begin
				rd_cnt_nxt = rd_cnt_r - 6'h01;
				rdw_nxt = (rd_cnt_r == 6'h01);
			end
			case (wr_st_r)
				ddr3_timing_pkg::WR_LEAD: begin
					wr_cnt_nxt = wr_cnt_r - 8'h01;
					if (wr_cnt_r == 8'h01) begin
						wrr_nxt = 1'b1;
						wr_cnt_nxt = twr_eff;
						wr_st_nxt = ddr3_timing_pkg::WR_REC;
					end
				end
				ddr3_timing_pkg::WR_REC: begin
					wr_cnt_nxt = (wr_cnt_r == 8'h00) ? 8'h00 : wr_cnt_r - 8'h01;
					if (wr_cnt_r <= 8'h01) wr_st_nxt = ddr3_timing_pkg::WR_IDLE;
				end
				default: wr_st_nxt = ddr3_timing_pkg::WR_IDLE;
			endcase
			// Internal precharge waits for the bank's row active minimum
			for (int b = 0; b < BANKS; b++) begin
				if (!found && pend_r[b] && ras_nxt[b] >= row_active_min_time &&
					!(pwr_r[b] && wr_st_r != ddr3_timing_pkg::WR_IDLE)) begin
					found = 1'b1;
					pend_nxt[b] = 1'b0;
					open_nxt[b] = 1'b0;
					rp_nxt[b] = 8'h00;
					ap_nxt = 1'b1;
					ap_bank_nxt = 3'(b);
				end
			end
			if (pin_s_r[10]) begin
				case (cmd_decode(pin_s_r[8:5]))
					ddr3_timing_pkg::CMD_ACT: begin
						// Spacing is judged in counted edges, never in nanoseconds
						if (rp_nxt[ba] < trp) viol_set = 1'b1;
						open_nxt[ba] = 1'b1;
						ras_nxt[ba] = 8'h00;
					end
					ddr3_timing_pkg::CMD_READ: begin
						rd_tgt_nxt = edges_nxt + {26'h0, rd_lat};
						rd_cnt_nxt = rd_lat;
						if (rd_lat == 6'h00) rdw_nxt = 1'b1;
						if (pin_s_r[1]) begin
							pend_nxt[ba] = 1'b1;
							pwr_nxt[ba] = 1'b0;
						end
					end
					ddr3_timing_pkg::CMD_WRITE: begin
						wr_cnt_nxt = {3'h0, wl} +
							((mode_r[1:0] == ddr3_timing_pkg::BURST_FIXED_CHOP)
							? ddr3_timing_pkg::WR_START_CHOP
							: ddr3_timing_pkg::WR_START_LONG);
						wr_tgt_nxt = edges_nxt + {24'h0, wr_cnt_nxt};
						wr_st_nxt = ddr3_timing_pkg::WR_LEAD;
						if (pin_s_r[1]) begin
							pend_nxt[ba] = 1'b1;
							pwr_nxt[ba] = 1'b1;
						end
					end
					ddr3_timing_pkg::CMD_PRE: begin
						for (int b = 0; b < BANKS; b++) begin
							if (pin_s_r[1] || ba == 3'(b)) begin
								open_nxt[b] = 1'b0;
								rp_nxt[b] = 8'h00;
							end
						end
					end
					default: ;
				endcase
			end
		end
		// A new violation wins over a software clear in the same cycle
		viol_nxt = viol_set | (viol_r & ~sw_clr);
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			edges_r <= 32'h0000_0000;
			rd_tgt_r <= 32'h0000_0000;
			wr_tgt_r <= 32'h0000_0000;
			rd_cnt_r <= 6'h00;
			wr_cnt_r <= 8'h00;
			wr_st_r <= ddr3_timing_pkg::WR_IDLE;
			open_r <= '0;
			pend_r <= '0;
			pwr_r <= '0;
			for (int b = 0; b < BANKS; b++) begin
				ras_r[b] <= 8'hFF;
				rp_r[b] <= 8'hFF;
			end
			viol_r <= 1'b0;
			READ_WINDOW_O <= 1'b0;
			WR_RECOVERY_O <= 1'b0;
			AUTO_PRE_O <= 1'b0;
			AUTO_PRE_BANK_O <= 3'h0;
		end else begin
			edges_r <= edges_nxt;
			rd_tgt_r <= rd_tgt_nxt;
			wr_tgt_r <= wr_tgt_nxt;
			rd_cnt_r <= rd_cnt_nxt;
			wr_cnt_r <= wr_cnt_nxt;
			wr_st_r <= wr_st_nxt;
			open_r <= open_nxt;
			pend_r <= pend_nxt;
			pwr_r <= pwr_nxt;
			ras_r <= ras_nxt;
			rp_r <= rp_nxt;
			viol_r <= viol_nxt;
			READ_WINDOW_O <= rdw_nxt;
			WR_RECOVERY_O <= wrr_nxt;
			AUTO_PRE_O <= ap_nxt;
			AUTO_PRE_BANK_O <= ap_bank_nxt;
		end
	end

	// AXI4-Lite slave: address and data are held separately, so either may come first
	logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awr_nxt, wr_nxt, bv_nxt, arr_nxt, rv_nxt;
	logic [1:0] br_nxt, rr_nxt;
	logic [31:0] rd_nxt;

	always_comb begin
		aw_full_nxt = aw_full_r;
		w_full_nxt = w_full_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		lat_nxt = lat_r;
		mode_nxt = mode_r;
		tim_nxt = tim_r;
		bv_nxt = S_AXI_BVALID_O && !S_AXI_BREADY_I;
		br_nxt = S_AXI_BRESP_O;
		rv_nxt = S_AXI_RVALID_O && !S_AXI_RREADY_I;
		rr_nxt = S_AXI_RRESP_O;
		rd_nxt = S_AXI_RDATA_O;
		sw_clr = 1'b0;
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			aw_full_nxt = 1'b1;
			aw_addr_nxt = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			w_full_nxt = 1'b1;
			w_data_nxt = S_AXI_WDATA_I;
			w_strb_nxt = S_AXI_WSTRB_I;
		end
		if (aw_full_r && w_full_r && !S_AXI_BVALID_O) begin
			aw_full_nxt = 1'b0;
			w_full_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = addr_ok(aw_addr_r, 1'b1) ? ddr3_timing_pkg::RESP_OKAY
				: ddr3_timing_pkg::RESP_SLVERR;
			case (aw_addr_r)
				ddr3_timing_pkg::LATENCY_OFS: lat_nxt = merge(lat_r, w_data_r, w_strb_r);
				ddr3_timing_pkg::MODE_OFS: mode_nxt = merge(mode_r, w_data_r, w_strb_r);
				ddr3_timing_pkg::TIMING_OFS: tim_nxt = merge(tim_r, w_data_r, w_strb_r);
				ddr3_timing_pkg::STATUS_OFS:
					sw_clr = w_strb_r[0] && w_data_r[ddr3_timing_pkg::VIOL_BIT];
				default: ;
			endcase
		end
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			rv_nxt = 1'b1;
			rr_nxt = addr_ok(S_AXI_ARADDR_I, 1'b0) ? ddr3_timing_pkg::RESP_OKAY
				: ddr3_timing_pkg::RESP_SLVERR;
			case (S_AXI_ARADDR_I)
				ddr3_timing_pkg::LATENCY_OFS: rd_nxt = lat_r;
				ddr3_timing_pkg::MODE_OFS: rd_nxt = mode_r;
				ddr3_timing_pkg::TIMING_OFS: rd_nxt = tim_r;
				ddr3_timing_pkg::STATUS_OFS: rd_nxt = {8'h00, pend_r, open_r, 7'h00, viol_r};
				ddr3_timing_pkg::EDGES_OFS: rd_nxt = edges_r;
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
		awr_nxt = !aw_full_nxt;
		wr_nxt = !w_full_nxt;
		arr_nxt = !rv_nxt;
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			lat_r <= ddr3_timing_pkg::LATENCY_RST;
			mode_r <= ddr3_timing_pkg::MODE_RST;
			tim_r <= ddr3_timing_pkg::TIMING_RST;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= 2'h0;
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RRESP_O <= 2'h0;
			S_AXI_RDATA_O <= 32'h0000_0000;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			lat_r <= lat_nxt;
			mode_r <= mode_nxt;
			tim_r <= tim_nxt;
			S_AXI_AWREADY_O <= awr_nxt;
			S_AXI_WREADY_O <= wr_nxt;
			S_AXI_BVALID_O <= bv_nxt;
			S_AXI_BRESP_O <= br_nxt;
			S_AXI_ARREADY_O <= arr_nxt;
			S_AXI_RVALID_O <= rv_nxt;
			S_AXI_RRESP_O <= rr_nxt;
			S_AXI_RDATA_O <= rd_nxt;
		end
	end

	edge_count_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(ck_edge && pin_s_r[9]) |=> edges_r == $past(edges_r) + 32'h0000_0001)
		else $error("clock edge not counted");
	read_window_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		READ_WINDOW_O |-> edges_r == rd_tgt_r)
		else $error("read window at wrong edge");
	wr_start_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		WR_RECOVERY_O |-> edges_r == wr_tgt_r && wr_st_r == ddr3_timing_pkg::WR_REC)
		else $error("write recovery start at wrong edge");
	auto_pre_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		AUTO_PRE_O |-> ras_r[AUTO_PRE_BANK_O] >= row_active_min_time && !open_r[AUTO_PRE_BANK_O])
		else $error("auto precharge before row active minimum");
	spacing_ok_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(!viol_r && ck_edge && pin_s_r[9] && pin_s_r[10] && pin_s_r[8:5] == 4'h3 &&
		rp_nxt[ba] >= trp) |=> !viol_r)
		else $error("legal spacing flagged");
endmodule

/* dv/ddr3_ctrl_model.sv */
// Behavioural DDR3 controller that drives the memory pins
module ddr3_ctrl_model (
	// Memory pins
	output logic ck_o,
	output logic cke_o,
	output logic rst_n_o,
	output logic [3:0] cmd_n_o,
	output logic [2:0] ba_o,
	output logic a10_o,
	output logic a12_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int edges = 0;
	logic hold = 1'b0;
	// Offset start keeps its edges away from the core clock edges
	initial begin
		ck_o = 1'b0;
		#3;
		forever #32 ck_o = ~ck_o;
	end
	initial begin
		rst_n_o = 1'b0;
		cke_o = 1'b0;
		cmd_n_o = 4'hF;
		ba_o = 3'h0;
		a10_o = 1'b0;
		a12_o = 1'b0;
	end
	always @(posedge ck_o) edges <= edges + 1;
	// Deselect after a command; the unused lines show junk, not the old command
	always @(negedge ck_o) begin
		if (hold) begin
			cmd_n_o <= {1'b1, ~cmd_n_o[2:0]};
			ba_o <= ~ba_o;
			a10_o <= ~a10_o;
			hold <= 1'b0;
		end
	end
	task automatic pins(input logic r, input logic c);
		@(negedge ck_o);
		rst_n_o <= r;
		cke_o <= c;
	endtask
	// Command lands no earlier than edge at; e returns the sampling edge
	task automatic cmd_at(input logic [3:0] c, input logic [2:0] b, input logic ap,
		input int at, output int e);
		@(negedge ck_o);
		while (hold || edges + 1 < at) @(negedge ck_o);
		cmd_n_o <= c;
		ba_o <= b;
		a10_o <= ap;
		a12_o <= ~a12_o;
		hold <= 1'b1;
		e = edges + 1;
	endtask
endmodule

/* dv/tb_ddr3_cmd_timing.sv */
// Self-checking bench for the DDR3 command timing tracker
`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		fails++; \
		$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module tb_ddr3_cmd_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ck, cke, ddr_rst_n, a10, a12, rd_win, wr_rec, ap;
	logic [3:0] cmd_n;
	logic [2:0] ba, ap_bank;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int fails = 0;
	int checks_done = 0;
	int seed = 60285;
	int qk[$];
	logic [33:0] qv[$];
	logic [33:0] qm[$];
	string kname[5] = '{"read_window", "wr_recovery", "auto_pre", "read_resp", "write_resp"};
	always #4 clk = ~clk;
	ddr3_ctrl_model mdl (.ck_o(ck), .cke_o(cke), .rst_n_o(ddr_rst_n), .cmd_n_o(cmd_n),
		.ba_o(ba), .a10_o(a10), .a12_o(a12));
	ddr3_cmd_timing dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n), .DDR_CK_I(ck), .DDR_CKE_I(cke),
		.DDR_RESET_N_I(ddr_rst_n), .DDR_CS_N_I(cmd_n[3]), .DDR_RAS_N_I(cmd_n[2]),
		.DDR_CAS_N_I(cmd_n[1]), .DDR_WE_N_I(cmd_n[0]), .DDR_BA_I(ba), .DDR_A10_I(a10),
		.DDR_A12_I(a12), .READ_WINDOW_O(rd_win), .WR_RECOVERY_O(wr_rec), .AUTO_PRE_O(ap),
		.AUTO_PRE_BANK_O(ap_bank), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
		.S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
	task automatic end_sim();
		fails += qk.size();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic lost(input string s);
		fails++;
		$display("MISMATCH %s expected event seen none", s);
		end_sim();
	endtask
	task automatic note(input int k, input logic [33:0] v, input logic [33:0] m = '1);
		qk.push_back(k);
		qv.push_back(v & m);
		qm.push_back(m);
	endtask
	// Every result retires the oldest note, so a stray pulse is caught too
	task automatic seen(input int k, input logic [33:0] v);
		checks_done++;
		if (qk.size() == 0) begin
			fails++;
			$display("MISMATCH %s expected none seen %0h", kname[k], v);
		end else begin
			checks_done--;
			`CHK(kname[k], {qk[0], qv[0]}, {k, v & qm[0]})
			void'(qk.pop_front());
			void'(qv.pop_front());
			void'(qm.pop_front());
		end
	endtask
	always @(posedge clk) begin
		if (rd_win === 1'b1) seen(0, 34'(mdl.edges));
		if (wr_rec === 1'b1) seen(1, 34'(mdl.edges));
		if (ap === 1'b1) seen(2, {mdl.edges[30:0], ap_bank});
		if (rvalid === 1'b1 && rready) seen(3, {rresp, rdata});
		if (bvalid === 1'b1 && bready) seen(4, {32'h0, bresp});
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clk);
		note(4, {32'h0, r});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 64) lost("bvalid");
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] v, input logic [33:0] m = '1);
		int n;
		@(posedge clk);
		note(3, v, m);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 64) lost("rvalid");
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	initial begin
		#400us;
		lost("watchdog");
	end
	initial begin
		int e, a, r, rl, al, wl, b;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		mdl.pins(1'b1, 1'b1);
		axi_rd(ddr3_timing_pkg::LATENCY_OFS, {2'h0, ddr3_timing_pkg::LATENCY_RST});
		axi_rd(ddr3_timing_pkg::MODE_OFS, {2'h0, ddr3_timing_pkg::MODE_RST});
		axi_rd(ddr3_timing_pkg::TIMING_OFS, {2'h0, ddr3_timing_pkg::TIMING_RST});
		axi_rd(8'h14, {ddr3_timing_pkg::RESP_SLVERR, 32'h0});
		axi_wr(ddr3_timing_pkg::EDGES_OFS, 32'h0, ddr3_timing_pkg::RESP_SLVERR);
		axi_wr(8'h1C, 32'h5, ddr3_timing_pkg::RESP_SLVERR);
		done("registers");
		for (int i = 0; i < 4; i++) begin
			rl = (i == 0) ? 1 : 5 + ($random(seed) & 7);
			al = (i == 0) ? 0 : $random(seed) & 3;
			wl = 5 + ($random(seed) & 7);
			axi_wr(ddr3_timing_pkg::LATENCY_OFS, 32'(wl << 16 | al << 8 | rl), 2'h0);
			axi_rd(ddr3_timing_pkg::LATENCY_OFS, 34'(wl << 16 | al << 8 | rl));
			repeat (12) @(posedge ck); // Relock wait after a latency change
			mdl.cmd_at(4'b0101, 3'(i), 1'b0, 0, e);
			note(0, 34'(e + ((rl + al > 1) ? rl + al - 1 : 0)));
			repeat (30) @(posedge ck);
		end
		done("read window");
		for (int m = 0; m < 3; m++) begin
			wl = 5 + ($random(seed) & 7);
			axi_wr(ddr3_timing_pkg::LATENCY_OFS, 32'(wl << 16 | 6), 2'h0);
			axi_wr(ddr3_timing_pkg::MODE_OFS, 32'(m | (m & 1) << 2), 2'h0);
			mdl.cmd_at(4'b0100, 3'($random(seed)), 1'b0, 0, e);
			note(1, 34'(e + wl + ((m == 2) ? 2 : 4)));
			repeat (30) @(posedge ck); // Generous write recovery before the next command
		end
		done("write recovery");
		axi_wr(ddr3_timing_pkg::LATENCY_OFS, ddr3_timing_pkg::LATENCY_RST, 2'h0);
		axi_wr(ddr3_timing_pkg::MODE_OFS, 32'h0, 2'h0);
		for (int i = 0; i < 2; i++) begin
			b = $random(seed) & 7; // Random banks spread the load
			mdl.cmd_at(4'b0011, 3'(b), 1'b0, 0, a);
			mdl.cmd_at(i ? 4'b0100 : 4'b0101, 3'(b), 1'b1, 0, r);
			note(i, 34'(r + (i ? 10 : 5)));
			note(2, 34'((i ? r + 17 : a + 15) * 8 + b));
			repeat (40) @(posedge ck);
		end
		done("auto precharge");
		b = $random(seed) & 7;
		mdl.cmd_at(4'b0011, 3'(b), 1'b0, 0, a);
		mdl.cmd_at(4'b0010, 3'(b), 1'b0, a + 15, r);
		mdl.cmd_at(4'b0011, 3'(b), 1'b0, r + 6, e);
		repeat (2) @(posedge ck);
		axi_rd(ddr3_timing_pkg::STATUS_OFS, 34'h0, 34'h300000001);
		mdl.cmd_at(4'b0010, 3'(b), 1'b0, e + 15, r);
		mdl.cmd_at(4'b0011, 3'(b), 1'b0, 0, e);
		repeat (2) @(posedge ck);
		axi_rd(ddr3_timing_pkg::STATUS_OFS, 34'h1, 34'h300000001);
		axi_wr(ddr3_timing_pkg::STATUS_OFS, 32'h1, 2'h0);
		axi_rd(ddr3_timing_pkg::STATUS_OFS, 34'h0, 34'h300000001);
		done("spacing");
		// Clock enable low hides the command; a memory reset drops a pending window
		mdl.pins(1'b1, 1'b0);
		mdl.cmd_at(4'b0101, 3'h1, 1'b0, 0, e);
		repeat (20) @(posedge ck);
		mdl.pins(1'b1, 1'b1);
		mdl.cmd_at(4'b0101, 3'h2, 1'b0, 0, e);
		mdl.pins(1'b0, 1'b1);
		repeat (20) @(posedge ck);
		mdl.pins(1'b1, 1'b1);
		repeat (10) @(posedge clk);
		done("pins");
		end_sim();
	end
endmodule
